//--- src/ckl_cfg.svh
`ifndef CKL_CFG_SVH
`define CKL_CFG_SVH

// register addresses, immediate space zero-extended to eight bits
`define CKL_ADDR_STATUS 8'h20
`define CKL_ADDR_LATCH 8'h21
`define CKL_ADDR_BOOST 8'h31
`define CKL_ADDR_AUDIO 8'h33
`define CKL_ADDR_CONV_WR 8'h36
`define CKL_ADDR_CONV_SET 8'h37
`define CKL_ADDR_CONV_CLR 8'h38
`define CKL_ADDR_IMM_MAX 8'h3f

// field positions
`define CKL_LATCH_ID_BIT 0
`define CKL_LATCH_MEAS_BIT 3
`define CKL_BOOST_LSB 5
`define CKL_CONV_DONE_BIT 3
`define CKL_CONV_GO_BIT 4
`define CKL_CONV_RSV_BIT 5
`define CKL_CONV_IRQ_BIT 6

// writable masks and key
`define CKL_CONV_WMASK 8'h77
`define CKL_AUDIO_KEY 4'ha
`define CKL_RESET_BYTE 8'h00

// conversion timing
`define CKL_CONV_TIME_US 282
`define CKL_CLK_MHZ 100
`define CKL_CONV_CYCLES (`CKL_CONV_TIME_US * `CKL_CLK_MHZ)

`endif

//--- src/ckl_pkg.sv
package ckl_pkg;

    // conversion sequencer states, gray coded
    typedef enum logic [0:0] {
        CKL_IDLE = 1'b0,
        CKL_BUSY = 1'b1
    } ckl_conv_state_t;

    typedef logic [7:0] ckl_byte_t;

endpackage

//--- src/ckl_regs.sv
`timescale 1ns/10ps
`include "ckl_cfg.svh"
//
// Contract
// - id float latch sets on enabled open-going or closed-going id pin edge
// - latch register is read-only; a read returns then clears its bits
// - interrupt-detect and dp latch bits always read zero
// - measure latch sets when done rises while either interrupt enable set
// - immediate registers decode from immediate address only; extended addresses read zero
// - vendor range is served by plain register reads and writes, except the conversion register with its set, clear and done-clearing read
// - two-bit amplitude field drives transmitter; other bits read zero
// - headset mode on only while key field holds exactly the key
// - resistance reported as three-bit code, 111 meaning error
// - done bit asserts itself when fixed-length conversion finishes
// - done clears on conversion register read, not on status read
// - go bit starts conversion on write or set, clears at completion
// - alt_int raised at completion if either interrupt enable set
// - conversion register has write, set and clear addresses, reads alike
// - rise enable sources open-going event, fall enable closed-going
module ckl_regs #(
    parameter int unsigned CONV_CYCLES = `CKL_CONV_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic id_float_in,
    input wire logic id_open_rise_enable_in,
    input wire logic id_open_fall_enable_in,
    input wire logic car_irq_enable_in,
    input wire logic [2:0] id_code_result_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [1:0] hs_amp_out,
    output logic headset_mode_out,
    output logic id_measure_go_out,
    output logic alt_int_out
);

    localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

    // conversion register address, any of its three aliases
    function automatic logic is_conv(input logic [7:0] a);
        is_conv = (a == `CKL_ADDR_CONV_WR) || (a == `CKL_ADDR_CONV_SET) ||
                  (a == `CKL_ADDR_CONV_CLR);
    endfunction

    logic id_float_event_flag;
    logic id_measure_event_flag;
    logic [1:0] hs_amp;
    logic [3:0] headset_mode_key;
    logic [2:0] id_resistance_code;
    logic id_measure_done;
    logic id_measure_go;
    logic conv_rsv;
    logic id_measure_irq_enable;
    ckl_pkg::ckl_conv_state_t state;
    logic [CNT_W-1:0] cnt;
    logic id_prev;
    logic id_armed;

    logic next_id_float_event_flag;
    logic next_id_measure_event_flag;
    logic [1:0] next_hs_amp;
    logic [3:0] next_headset_mode_key;
    logic [2:0] next_id_resistance_code;
    logic next_id_measure_done;
    logic next_id_measure_go;
    logic next_conv_rsv;
    logic next_id_measure_irq_enable;
    ckl_pkg::ckl_conv_state_t next_state;
    logic [CNT_W-1:0] next_cnt;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_alt_int;
    logic next_headset_mode;

    logic rd_latch;
    logic rd_conv;
    logic id_event;
    logic finish;
    logic any_irq_en;
    ckl_pkg::ckl_byte_t conv_byte;
    ckl_pkg::ckl_byte_t conv_next;
    ckl_pkg::ckl_byte_t wmasked;

    // event and access decode
    always_comb begin
        rd_latch = reg_rd_in && (reg_addr_in == `CKL_ADDR_LATCH);
        rd_conv = reg_rd_in && is_conv(reg_addr_in);
        // edge source select
        // no edge until id_prev holds a real pin sample after reset
        id_event = id_armed &&
                   ((id_float_in && !id_prev && id_open_rise_enable_in) ||
                    (!id_float_in && id_prev && id_open_fall_enable_in));
        finish = (state == ckl_pkg::CKL_BUSY) && (cnt == CNT_LAST);
        any_irq_en = id_measure_irq_enable || car_irq_enable_in;
        conv_byte = {1'b0, id_measure_irq_enable, conv_rsv, id_measure_go,
                     id_measure_done, id_resistance_code};
        wmasked = reg_wdata_in & `CKL_CONV_WMASK;
    end

    // latch register next values
    always_comb begin
        next_id_float_event_flag = id_float_event_flag;
        next_id_measure_event_flag = id_measure_event_flag;
        if (rd_latch) begin
            next_id_float_event_flag = 1'b0;
            next_id_measure_event_flag = 1'b0;
        end
        if (id_event) begin
            next_id_float_event_flag = 1'b1;
        end
        if (finish && !id_measure_done && any_irq_en) begin
            next_id_measure_event_flag = 1'b1;
        end
    end

    // plain vendor registers
    always_comb begin
        next_hs_amp = hs_amp;
        next_headset_mode_key = headset_mode_key;
        if (reg_wr_in && (reg_addr_in == `CKL_ADDR_BOOST)) begin
            next_hs_amp = reg_wdata_in[`CKL_BOOST_LSB +: 2];
        end
        if (reg_wr_in && (reg_addr_in == `CKL_ADDR_AUDIO)) begin
            next_headset_mode_key = reg_wdata_in[3:0];
        end
        next_headset_mode = (next_headset_mode_key == `CKL_AUDIO_KEY);
    end

    // conversion register and sequencer
    always_comb begin
        conv_next = conv_byte;
        if (reg_wr_in && (reg_addr_in == `CKL_ADDR_CONV_WR)) begin
            conv_next = wmasked | (conv_byte & ~`CKL_CONV_WMASK);
        end else if (reg_wr_in && (reg_addr_in == `CKL_ADDR_CONV_SET)) begin
            conv_next = conv_byte | wmasked;
        end else if (reg_wr_in && (reg_addr_in == `CKL_ADDR_CONV_CLR)) begin
            conv_next = conv_byte & ~wmasked;
        end
        if (rd_conv) begin
            conv_next[`CKL_CONV_DONE_BIT] = 1'b0;
        end
        next_state = state;
        next_cnt = cnt;
        next_alt_int = 1'b0;
        unique case (state)
            ckl_pkg::CKL_IDLE: begin
                if (conv_next[`CKL_CONV_GO_BIT]) begin
                    next_state = ckl_pkg::CKL_BUSY;
                    next_cnt = '0;
                end
            end
            ckl_pkg::CKL_BUSY: begin
                if (finish) begin
                    // done on completion, wins over read
                    conv_next[`CKL_CONV_DONE_BIT] = 1'b1;
                    conv_next[`CKL_CONV_GO_BIT] = 1'b0;
                    conv_next[2:0] = id_code_result_in;
                    next_alt_int = any_irq_en;
                    next_state = ckl_pkg::CKL_IDLE;
                end else if (!conv_next[`CKL_CONV_GO_BIT]) begin
                    next_state = ckl_pkg::CKL_IDLE; // software abort
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
        endcase
        next_id_resistance_code = conv_next[2:0];
        next_id_measure_done = conv_next[`CKL_CONV_DONE_BIT];
        next_id_measure_go = conv_next[`CKL_CONV_GO_BIT];
        // reserved bit kept as the link writes it
        next_conv_rsv = conv_next[`CKL_CONV_RSV_BIT];
        next_id_measure_irq_enable = conv_next[`CKL_CONV_IRQ_BIT];
    end

    // read data mux
    always_comb begin
        next_rvalid = reg_rd_in;
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            // one decode on the full eight-bit address, no alias
            unique case (reg_addr_in)
                `CKL_ADDR_STATUS: begin
                    next_rdata = {1'b0, id_measure_done, id_resistance_code,
                                  2'b00, id_float_in};
                end
                `CKL_ADDR_LATCH: begin
                    next_rdata = {4'h0, id_measure_event_flag, 2'b00,
                                  id_float_event_flag};
                end
                `CKL_ADDR_BOOST: next_rdata = {1'b0, hs_amp, 5'b0_0000};
                `CKL_ADDR_AUDIO: next_rdata = {4'h0, headset_mode_key};
                `CKL_ADDR_CONV_WR,
                `CKL_ADDR_CONV_SET,
                `CKL_ADDR_CONV_CLR: next_rdata = conv_byte;
                default: next_rdata = `CKL_RESET_BYTE;
            endcase
        end
    end

    // state registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            id_float_event_flag <= 1'b0;
            id_measure_event_flag <= 1'b0;
            hs_amp <= 2'b00;
            headset_mode_key <= 4'h0;
            id_resistance_code <= 3'b000;
            id_measure_done <= 1'b0;
            id_measure_go <= 1'b0;
            conv_rsv <= 1'b0;
            id_measure_irq_enable <= 1'b0;
            state <= ckl_pkg::CKL_IDLE;
            cnt <= '0;
            id_prev <= 1'b0;
            id_armed <= 1'b0;
            reg_rdata_out <= `CKL_RESET_BYTE;
            reg_rvalid_out <= 1'b0;
            alt_int_out <= 1'b0;
            headset_mode_out <= 1'b0;
        end else begin
            id_float_event_flag <= next_id_float_event_flag;
            id_measure_event_flag <= next_id_measure_event_flag;
            hs_amp <= next_hs_amp;
            headset_mode_key <= next_headset_mode_key;
            id_resistance_code <= next_id_resistance_code;
            id_measure_done <= next_id_measure_done;
            id_measure_go <= next_id_measure_go;
            conv_rsv <= next_conv_rsv;
            id_measure_irq_enable <= next_id_measure_irq_enable;
            state <= next_state;
            cnt <= next_cnt;
            id_prev <= id_float_in;
            id_armed <= 1'b1;
            reg_rdata_out <= next_rdata;
            reg_rvalid_out <= next_rvalid;
            alt_int_out <= next_alt_int;
            headset_mode_out <= next_headset_mode;
        end
    end

    // outputs straight from flops
    assign hs_amp_out = hs_amp;
    assign id_measure_go_out = id_measure_go;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_id_latch_set;
        id_event |=> id_float_event_flag;
    endproperty
    a_id_latch_set: assert property (p_id_latch_set)
        else $error("id float latch missed an enabled edge");

    property p_latch_rc;
        (rd_latch && !id_event) |=> !id_float_event_flag;
    endproperty
    a_latch_rc: assert property (p_latch_rc)
        else $error("latch not cleared by read");

    property p_latch_zero;
        (rd_latch ##1 reg_rvalid_out) |-> (reg_rdata_out[2:1] == 2'b00);
    endproperty
    a_latch_zero: assert property (p_latch_zero)
        else $error("unimplemented latch bits not zero");

    property p_meas_latch;
        (finish && !id_measure_done && any_irq_en) |=> id_measure_event_flag;
    endproperty
    a_meas_latch: assert property (p_meas_latch)
        else $error("measure latch missed done edge");

    property p_boost_zero;
        (reg_rd_in && reg_addr_in == `CKL_ADDR_BOOST) |=>
            (reg_rdata_out[4:0] == 5'b0_0000) && !reg_rdata_out[7] &&
            (reg_rdata_out[6:5] == hs_amp);
    endproperty
    a_boost_zero: assert property (p_boost_zero)
        else $error("amplitude register read wrong");

    property p_headset;
        headset_mode_out == (headset_mode_key == `CKL_AUDIO_KEY);
    endproperty
    a_headset: assert property (p_headset)
        else $error("headset mode disagrees with key");

    property p_conv_len;
        (state == ckl_pkg::CKL_BUSY) |-> (cnt <= CNT_LAST);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion ran past its length");

    property p_status_keeps;
        (reg_rd_in && reg_addr_in == `CKL_ADDR_STATUS && id_measure_done) |=>
            id_measure_done;
    endproperty
    a_status_keeps: assert property (p_status_keeps)
        else $error("status read cleared done");

    property p_finish_go;
        finish |=> (!id_measure_go && id_measure_done);
    endproperty
    a_finish_go: assert property (p_finish_go)
        else $error("completion did not clear go and set done");

    property p_alt_int;
        finish |=> (alt_int_out == $past(any_irq_en));
    endproperty
    a_alt_int: assert property (p_alt_int)
        else $error("alt_int wrong at completion");

endmodule

//--- verif/ckl_link_model.sv
`timescale 1ns/10ps
// link side of the register port plus the analog id converter
module ckl_link_model (
    input wire logic ref_clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic go_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out,
    output logic [2:0] code_out
);
    logic [2:0] code_val = 3'h0;
    logic [2:0] pat = 3'h0;

    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    // converter result only meaningful while running
    always @(posedge ref_clk_in) pat <= pat + 3'h3;
    assign code_out = (go_in === 1'b1) ? code_val : pat;

    // one write strobe, released bus shows inverted values, then one idle cycle
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        wdata_out = (a == 8'h36 || a == 8'h37) ? (d & 8'hdf) : d;
        wr_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~wdata_out;
        // idle cycle keeps a following call off this time step
        @(posedge ref_clk_in);
        #1;
    endtask

    // one read strobe, answer taken one cycle later, then one idle cycle
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        addr_out = a;
        rd_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        ok = rvalid_in;
        d = rdata_in;
        @(posedge ref_clk_in);
        #1;
    endtask
endmodule

//--- verif/ckl_regs_tb.sv
`timescale 1ns/10ps
module ckl_regs_tb;
    localparam int unsigned CONV = 10;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr, wdata, rdata, rv;
    logic wr, rd, rvalid, ok, headset, go, alt;
    logic idf = 1'b0;
    logic rise_en = 1'b0;
    logic fall_en = 1'b0;
    logic car_en = 1'b0;
    logic [2:0] code;
    logic [1:0] amp;
    int errors = 0;
    int cmp_count = 0;
    int alt_cnt = 0;

    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (alt === 1'b1) alt_cnt <= alt_cnt + 1;

    ckl_regs #(.CONV_CYCLES(CONV)) ckl_regs_inst (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .id_float_in(idf), .id_open_rise_enable_in(rise_en),
        .id_open_fall_enable_in(fall_en), .car_irq_enable_in(car_en),
        .id_code_result_in(code), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .hs_amp_out(amp), .headset_mode_out(headset), .id_measure_go_out(go),
        .alt_int_out(alt));

    ckl_link_model ckl_link_model_inst (
        .ref_clk_in(ref_clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .go_in(go),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata), .code_out(code));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        ckl_link_model_inst.write_reg(a, d);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        ckl_link_model_inst.read_reg(a, rv, ok);
        check("rvalid", {7'h0, ok}, 8'h01);
        check(nm, rv, exp);
    endtask

    task automatic end_sim();
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // one conversion, started by write or set, then all readbacks
    task automatic run_conv(input logic ven, input logic car, input logic [2:0] c,
                            input logic use_set);
        int n;
        int a0;
        // the write's idle cycle is the first cycle that go stands
        n = 1;
        a0 = alt_cnt;
        car_en = car;
        ckl_link_model_inst.code_val = c;
        wr_reg(8'h36, {1'b0, ven, 6'h00});
        wr_reg(use_set ? 8'h37 : 8'h36, {1'b0, ven, 2'b01, 4'h0});
        check("go", {7'h0, go}, 8'h01);
        for (int k = 0; k < 100 && go === 1'b1; k++) begin
            wait_cyc(1);
            n++;
        end
        if (go !== 1'b0) begin
            errors++;
            end_sim();
        end
        check("conv len", n[7:0], 8'(CONV));
        rd_chk("status", 8'h20, {2'b01, c, 2'b00, idf});
        rd_chk("latch", 8'h21, {4'h0, ven | car, 3'h0});
        rd_chk("conv clr", 8'h38, {1'b0, ven, 3'b001, c});
        rd_chk("conv", 8'h36, {1'b0, ven, 3'b000, c});
        check("alt", 8'(alt_cnt - a0), {7'h0, ven | car});
    endtask

    initial begin
        wait_cyc(4);
        rst_in = 1'b0;
        check("outs", {2'b00, amp, headset, go, alt, 1'b0}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset", 8'h30 + 8'(i), 8'h00);
        end
        rd_chk("latch rst", 8'h21, 8'h00);
        wr_reg(8'h21, 8'hff);
        wr_reg(8'h20, 8'hff);
        rd_chk("latch ro", 8'h21, 8'h00);
        rd_chk("status ro", 8'h20, 8'h00);
        wr_reg(8'h36, 8'h88);
        rd_chk("conv ro", 8'h36, 8'h00);
        wr_reg(8'h36, 8'h41);
        wr_reg(8'h37, 8'h02);
        rd_chk("conv set", 8'h37, 8'h43);
        wr_reg(8'h38, 8'h41);
        rd_chk("conv clr", 8'h36, 8'h02);
        wr_reg(8'h38, 8'hff);
        // extended address above the immediate set must not alias it
        wr_reg(8'h71, 8'h60);
        check("ext wr", {6'h0, amp}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h31, {1'b1, 2'(i), 5'h1f});
            check("amp", {6'h0, amp}, 8'(i));
            rd_chk("boost", 8'h31, {1'b0, 2'(i), 5'h00});
        end
        rd_chk("ext rd", 8'hb1, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr_reg(8'h33, {4'hf, 4'(i)});
            check("headset", {7'h0, headset}, {7'h0, i == 10});
            rd_chk("audio", 8'h33, {4'h0, 4'(i)});
        end
        rise_en = 1'b1;
        idf = 1'b1;
        wait_cyc(3);
        rd_chk("rise ev", 8'h21, 8'h01);
        rd_chk("cleared", 8'h21, 8'h00);
        idf = 1'b0;
        wait_cyc(3);
        rd_chk("fall off", 8'h21, 8'h00);
        rise_en = 1'b0;
        fall_en = 1'b1;
        idf = 1'b1;
        wait_cyc(3);
        idf = 1'b0;
        wait_cyc(3);
        rd_chk("fall ev", 8'h21, 8'h01);
        fall_en = 1'b0;
        rise_en = 1'b1;
        idf = 1'b1;
        ckl_link_model_inst.read_reg(8'h21, rv, ok);
        check("pre ev", rv, 8'h00);
        wait_cyc(3);
        rd_chk("kept ev", 8'h21, 8'h01);
        rise_en = 1'b0;
        run_conv(1'b1, 1'b0, 3'b101, 1'b1);
        run_conv(1'b0, 1'b1, 3'b111, 1'b0);
        run_conv(1'b0, 1'b0, 3'b010, 1'b1);
        wr_reg(8'h37, 8'h10);
        wr_reg(8'h38, 8'h10);
        wait_cyc(CONV + 4);
        rd_chk("abort", 8'h36, 8'h02);
        end_sim();
    end
endmodule
